// ### design/ebcs_top.v
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "ebcs_defs.vh"
// How it works
// [R01] Each bus cycle walks setup, command delay and data setup when nonzero, access, hold.
// [R02] Phase lengths come from the timing register; delay 0-3, access 1-32.
// [R03] Address setup is 1 or 2 periods, plus 0-3 when the window changes.
// [R04] Data setup / mux turnaround phase is 0 or 1 period.
// [R05] Hold phase keeps address and write data for 1-3 periods; a zero hold field gives 1.
// [R06] Read data is captured on the edge that raises the read strobe.
// [R07] Address changes after strobe end never corrupt captured data.
// [R08] The far side keeps read data valid until the read strobe rises.
// [R09] No new cycle starts before the hold phase has fully ended.
module ebcs_top #(
  parameter AW = 24,
  parameter DW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg [AW-1:0] bus_addr,
  output reg [DW-1:0] bus_wdata,
  output reg bus_data_oe,
  input wire [DW-1:0] bus_rdata,
  output reg read_strobe_n,
  output reg write_strobe_n,
  output reg addr_latch,
  output reg high_byte_enable_n,
  output wire bus_reference_clock_out,
  output reg bus_busy
);
  localparam S_IDLE = 3'h0;
  localparam S_AB = 3'h1;
  localparam S_C = 3'h2;
  localparam S_D = 3'h3;
  localparam S_E = 3'h4;
  localparam S_F = 3'h5;

  reg [2:0] state;
  reg [5:0] cnt;
  reg [31:0] chip_select_timing_ctrl;
  reg [AW-1:0] addr_reg;
  reg [DW-1:0] wdata_reg;
  reg is_write;
  reg bhe_reg;
  reg [DW-1:0] rd_capture;
  reg [AW-1:0] last_addr;
  reg start_req;
  reg ap_valid;
  reg ap_write;
  reg [3:0] ap_addr;
  wire [DW-1:0] rdata_sync;
  wire win_change;
  wire mux_mode;
  reg [5:0] len_ab;
  reg [1:0] cap_pend;
  wire reg_hit;

  // Phase lengths from timing fields
  wire [5:0] len_c = {4'h0,
    chip_select_timing_ctrl[`EBCS_F_C_LSB+1:`EBCS_F_C_LSB]}; // [R02]
  wire [5:0] len_d = {5'h00,
    chip_select_timing_ctrl[`EBCS_F_D_LSB]}; // [R04]
  wire [5:0] len_e = {1'b0,
    chip_select_timing_ctrl[`EBCS_F_E_LSB+4:`EBCS_F_E_LSB]} + 6'h01; // [R02]
  wire [5:0] len_f = {4'h0,
    chip_select_timing_ctrl[`EBCS_F_F_LSB+1:`EBCS_F_F_LSB]}; // [R05]
  assign mux_mode = chip_select_timing_ctrl[`EBCS_F_MUX_BIT];
  // Only the low register words decode; anything above reads zero
  assign reg_hit = ~|haddr[31:`EBCS_A_BITS];
  assign win_change = (addr_reg[AW-1:`EBCS_WIN_LSB] !=
    last_addr[AW-1:`EBCS_WIN_LSB]);

  always @* begin
    len_ab = {5'h00, chip_select_timing_ctrl[`EBCS_F_AB_LSB]} + 6'h01;
    if (win_change) begin
      len_ab = len_ab + {4'h0,
        chip_select_timing_ctrl[`EBCS_F_ABX_LSB+1:`EBCS_F_ABX_LSB]}; // [R03]
    end
  end

  ebcs_clkdiv u_clkdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_out(bus_reference_clock_out)
  );

  ebcs_sync #(.WIDTH(DW)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(bus_rdata),
    .q(rdata_sync)
  );

  // Next phase after the given one, skipping zero-length phases
  function [2:0] next_phase;
    input [2:0] cur;
    input [5:0] lc;
    input [5:0] ld;
    begin
      case (cur)
        S_AB: next_phase = (lc != 6'h00) ? S_C :
          ((ld != 6'h00) ? S_D : S_E);
        S_C: next_phase = (ld != 6'h00) ? S_D : S_E;
        S_D: next_phase = S_E;
        default: next_phase = S_E;
      endcase
    end
  endfunction

  function [5:0] phase_len;
    input [2:0] ph;
    input [5:0] lc;
    input [5:0] ld;
    input [5:0] le;
    begin
      case (ph)
        S_C: phase_len = lc;
        S_D: phase_len = ld;
        default: phase_len = le;
      endcase
    end
  endfunction

  // AHB-Lite slave, zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 4'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        ap_valid <= hsel & htrans[1] & reg_hit;
        ap_write <= hwrite;
        ap_addr <= haddr[3:0];
      end
    end
  end

  // Read data mux, registered at address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (!reg_hit) begin
        hrdata <= 32'h00000000;
      end else begin
        case (haddr[3:0])
          `EBCS_A_TIMING: hrdata <= chip_select_timing_ctrl;
          `EBCS_A_ADDR: hrdata <= {{(32-AW){1'b0}}, addr_reg};
          `EBCS_A_CMD: hrdata <= {{(32-DW){1'b0}}, rd_capture};
          `EBCS_A_STAT: hrdata <= {29'h00000000, state};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Register writes; command write queues a bus cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_select_timing_ctrl <= `EBCS_TIMING_RST;
      addr_reg <= {AW{1'b0}};
      wdata_reg <= {DW{1'b0}};
      is_write <= 1'b0;
      bhe_reg <= 1'b0;
      start_req <= 1'b0;
    end else begin
      if (state == S_AB) begin
        start_req <= 1'b0;
      end
      if (ap_valid && ap_write) begin
        case (ap_addr)
          `EBCS_A_TIMING: begin
            if (state == S_IDLE) begin
              chip_select_timing_ctrl <= hwdata;
            end
          end
          `EBCS_A_ADDR: begin
            if (state == S_IDLE) begin
              addr_reg <= hwdata[AW-1:0];
            end
          end
          `EBCS_A_CMD: begin
            if (state == S_IDLE && !start_req) begin
              wdata_reg <= hwdata[DW-1:0];
              is_write <= hwdata[`EBCS_F_WR_BIT];
              bhe_reg <= hwdata[`EBCS_F_BHE_BIT];
              start_req <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Phase sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      cnt <= 6'h00;
      last_addr <= {AW{1'b0}};
      bus_busy <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_req) begin
            state <= S_AB; // [R01]
            cnt <= len_ab; // [R03]
            bus_busy <= 1'b1;
          end
        end
        S_AB, S_C, S_D: begin
          if (cnt <= 6'h01) begin
            state <= next_phase(state, len_c, len_d); // [R01]
            cnt <= phase_len(next_phase(state, len_c, len_d),
              len_c, len_d, len_e); // [R02]
            if (state == S_AB) begin
              last_addr <= addr_reg;
            end
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        S_E: begin
          if (cnt <= 6'h01) begin
            state <= S_F; // [R01]
            cnt <= len_f; // [R05]
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        S_F: begin
          // Zero-length hold still passes through here once
          if (cnt <= 6'h01) begin
            state <= S_IDLE; // [R09]
            bus_busy <= 1'b0;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        default: begin
          state <= S_IDLE;
          bus_busy <= 1'b0;
        end
      endcase
    end
  end

  // Pin drive and read capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_addr <= {AW{1'b0}};
      bus_wdata <= {DW{1'b0}};
      bus_data_oe <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      addr_latch <= 1'b0;
      high_byte_enable_n <= 1'b1;
      rd_capture <= {DW{1'b0}};
      cap_pend <= 2'b00;
    end else begin
      addr_latch <= 1'b0;
      cap_pend <= {cap_pend[0], 1'b0};
      if (cap_pend[1]) begin
        // Sync output now holds the pins seen at strobe end
        rd_capture <= rdata_sync; // [R06]
      end
      if (state == S_IDLE && start_req) begin
        bus_addr <= addr_reg;
        high_byte_enable_n <= ~bhe_reg;
        addr_latch <= 1'b1;
      end
      if (state == S_AB && cnt <= 6'h01) begin
        // Mux bus turns around before data
        bus_data_oe <= is_write; // [R04]
        bus_wdata <= wdata_reg;
      end
      if (state != S_E && next_phase(state, len_c, len_d) == S_E &&
          state != S_IDLE && state != S_F && cnt <= 6'h01) begin
        read_strobe_n <= is_write;
        write_strobe_n <= ~is_write;
      end
      if (state == S_E && cnt <= 6'h01) begin
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        if (!is_write) begin
          // Pins latched on this edge; later address moves harmless
          cap_pend[0] <= 1'b1; // [R06] [R07] [R08]
        end
        if (mux_mode && !is_write) begin
          bus_data_oe <= 1'b0;
        end
      end
      if (state == S_F && cnt <= 6'h01) begin
        bus_data_oe <= 1'b0; // [R05]
      end
    end
  end
endmodule

// ### design/ebcs_defs.vh
`ifndef EBCS_DEFS_VH
`define EBCS_DEFS_VH
// Register byte addresses
`define EBCS_A_TIMING 4'h0
`define EBCS_A_ADDR 4'h4
`define EBCS_A_CMD 4'h8
`define EBCS_A_STAT 4'hC
// Register space: address bits below this decode a register
`define EBCS_A_BITS 4
// Timing register fields
`define EBCS_F_AB_LSB 0
`define EBCS_F_AB_W 1
`define EBCS_F_ABX_LSB 1
`define EBCS_F_C_LSB 4
`define EBCS_F_D_LSB 8
`define EBCS_F_E_LSB 12
`define EBCS_F_F_LSB 20
`define EBCS_F_MUX_BIT 24
`define EBCS_TIMING_RST 32'h00000000
// Command register fields
`define EBCS_F_WR_BIT 16
`define EBCS_F_BHE_BIT 17
// Address window: upper address bits
`define EBCS_WIN_LSB 16
`endif

// ### design/ebcs_clkdiv.v
`timescale 1ns/1ps
// Bus reference clock, toggled each cpu clock
module ebcs_clkdiv (
  input wire hclk,
  input wire hresetn,
  output reg clk_out
);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= ~clk_out;
    end
  end
endmodule

// ### design/ebcs_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module ebcs_sync #(
  parameter WIDTH = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ### test/ebcs_props.sv
`timescale 1ns/1ps
module ebcs_props #(
  parameter AW = 24,
  parameter DW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire [AW-1:0] bus_addr,
  input wire [DW-1:0] bus_wdata,
  input wire bus_data_oe,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire addr_latch,
  input wire bus_busy
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wr_end;
    ##[1:32] $rose(write_strobe_n);
  endsequence
  sequence s_rd_end;
    ##[1:32] $rose(read_strobe_n);
  endsequence
  strobe_excl_a:
    assert property (read_strobe_n || write_strobe_n) else $error("strobes");
  latch_start_a:
    assert property ($rose(bus_busy) |-> addr_latch) else $error("latch");
  latch_gap_a:
    assert property (addr_latch |-> !$past(bus_busy)) else $error("overlap");
  strobe_busy_a:
    assert property (!(read_strobe_n && write_strobe_n) |->
      bus_busy && !addr_latch) else $error("strobe out of cycle");
  wr_access_a:
    assert property ($fell(write_strobe_n) |-> s_wr_end) else $error("wr len");
  rd_access_a:
    assert property ($fell(read_strobe_n) |-> s_rd_end) else $error("rd len");
  addr_steady_a:
    assert property (!read_strobe_n |=> read_strobe_n || $stable(bus_addr))
      else $error("addr moved");
  wdata_hold_a:
    assert property ($rose(write_strobe_n) |-> $stable(bus_wdata) &&
      $stable(bus_addr) && bus_busy) else $error("hold");
  oe_dir_a:
    assert property (!(read_strobe_n && write_strobe_n) |->
      bus_data_oe == !write_strobe_n) else $error("oe");
endmodule
bind ebcs_top ebcs_props #(.AW(AW), .DW(DW)) i_props (.hclk(hclk),
  .hresetn(hresetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_data_oe(bus_data_oe), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .addr_latch(addr_latch),
  .bus_busy(bus_busy));

// ### test/ebcs_mem.sv
`timescale 1ns/1ps
module ebcs_mem (
  input wire [23:0] addr,
  input wire [15:0] wdata,
  input wire rd_n,
  input wire wr_n,
  input wire slow,
  output logic [15:0] rdata
);
  logic [15:0] m [0:255];
  initial rdata = 16'h0;
  always @(posedge wr_n) m[addr[7:0]] = wdata;
  always @(negedge rd_n) begin
    rdata = ~m[addr[7:0]];
    #(slow ? 60 : 1);
    if (!rd_n) rdata = m[addr[7:0]];
  end
  // Released: show the inverse, never the old value
  always @(posedge rd_n) rdata = ~rdata;
endmodule

// ### test/ebcs_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_mismatch++;\
 $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module ebcs_top_tb_top;
  logic hclk = 0, hresetn = 0, hwrite = 0, slow = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic hreadyout, bus_data_oe, read_strobe_n, write_strobe_n;
  logic addr_latch, bus_busy, hresp, hben, refclk;
  logic [23:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, mem [0:255];
  logic [7:0] pw = 0;
  int n_mismatch = 0, checks_done = 0, nb = 0, ns = 0;
  always #25 hclk = ~hclk;
  ebcs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_data_oe(bus_data_oe),
    .bus_rdata(bus_rdata), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .addr_latch(addr_latch),
    .high_byte_enable_n(hben), .bus_reference_clock_out(refclk),
    .bus_busy(bus_busy));
  ebcs_mem i_mem (.addr(bus_addr), .wdata(bus_wdata), .rd_n(read_strobe_n),
    .wr_n(write_strobe_n), .slow(slow), .rdata(bus_rdata));
  always @(posedge hclk) begin
    if (bus_busy) nb <= nb + 1;
    if (!(read_strobe_n && write_strobe_n)) ns <= ns + 1;
  end
  task automatic xfer(logic w, logic [31:0] a, wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  function automatic int exp_len(logic [31:0] t, logic wc);
    return 2 + t[0] + (wc ? t[2:1] : 0) + t[5:4] + t[8] + t[16:12] +
      (t[21:20] != 2'h0 ? t[21:20] : 1);
  endfunction
  task automatic run(logic w, logic [23:0] a, logic [15:0] d, logic [31:0] t);
    logic [31:0] r;
    int k;
    logic b;
    k = 0;
    b = 1'($urandom);
    xfer(1'h1, 32'h0, t, r);
    xfer(1'h1, 32'h4, {8'h0, a}, r);
    nb = 0;
    ns = 0;
    xfer(1'h1, 32'h8, {14'h0, b, w, d}, r);
    xfer(1'h1, 32'h0, 32'h0, r);
    while (bus_busy !== 1'h0 && k++ < 200) @(negedge hclk);
    if (k > 200) n_mismatch++;
    `CHK("hbe", ~b, hben)
    xfer(1'h0, 32'h0, 32'h0, r);
    `CHK("timing", t, r)
    `CHK("busy_len", exp_len(t, a[23:16] != pw), nb)
    `CHK("strobe_len", 1 + t[16:12], ns)
    pw = a[23:16];
    if (w) mem[a[7:0]] = d;
    else begin
      xfer(1'h0, 32'h8, 32'h0, r);
      `CHK("rdata", mem[a[7:0]], r[15:0])
    end
  endtask
  task report_and_stop;
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    logic [31:0] t, r;
    logic c;
    logic [23:0] a;
    logic [15:0] d;
    void'($urandom(32'hBA14));
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      t = (i == 0) ? 32'h0 : (i == 1) ? 32'h131F137 : $urandom & 32'h131F137;
      a = 24'($urandom) & 24'h0300FF;
      d = 16'($urandom);
      slow <= t[16:12] > 5'h3;
      run(1'h1, a, d, t);
      run(1'h0, a, 16'h0, t);
    end
    xfer(1'h0, 32'h10, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    xfer(1'h0, 32'hC, 32'h0, r);
    `CHK("status", 32'h0, r)
    `CHK("hresp", 1'h0, hresp)
    @(negedge hclk) c = refclk;
    @(negedge hclk) `CHK("refclk", ~c, refclk)
    report_and_stop;
  end
endmodule
